// File: hdl/node_cfg_consts.vh
/*
 * Constants of the node configuration message port: token codes,
 * register numbers, storage slots and field padding.
 * Assumes it is included by its bare name from the design files.
 */
`ifndef NODE_CFG_CONSTS_VH
`define NODE_CFG_CONSTS_VH

// ==========================================================================
// Control token codes
// ==========================================================================
`define TOK_WRITE    8'hC0
`define TOK_READ     8'hC1
`define TOK_END      8'h01
`define TOK_ACK      8'h03
`define TOK_NACK     8'h04

// ==========================================================================
// Register numbers
// ==========================================================================
`define RN_IDENT     16'h0000
`define RN_SWDESC    16'h0001
`define RN_SWCFG     16'h0004
`define RN_NODEID    16'h0005
`define RN_PLL       16'h0006
`define RN_SWDIV     16'h0007
`define RN_REFCLK    16'h0008
`define RN_DIRLO     16'h000C
`define RN_DIRHI     16'h000D
`define RN_DBGPIN    16'h0010
`define RN_DBGSRC    16'h001F
`define RN_LINKST    16'h0020
`define RN_PROCESSOR_LINK     16'h0040
`define RN_LINKCFG   16'h0080
`define RN_STATIC    16'h00A0
`define RN_GRP8_MASK 16'hFFF8
`define RN_GRP4_MASK 16'hFFFC

// ==========================================================================
// Storage slots of the writable registers
// ==========================================================================
`define SLOT_SWCFG   6'h00
`define SLOT_DIRLO   6'h05
`define SLOT_DIRHI   6'h06
`define SLOT_DBGPIN  6'h07
`define SLOT_LINKST  6'h08
`define SLOT_PROCESSOR_LINK   6'h10
`define SLOT_LINKCFG 6'h18
`define SLOT_STATIC  6'h20

// ==========================================================================
// Reset values, padding and counts
// ==========================================================================
`define REG_RESET    32'h0000_0000
`define ID_MODE_PAD  6'h00
`define DESC_PAD     16'h0000
`define SYNC_SETTLE  2'h3
`define CNT_RID      2'h2
`define CNT_RNUM     2'h1
`define CNT_DATA     2'h3
`define TX_LEFT_RD   3'h5
`define TX_LEFT_SHORT 3'h1

`endif

// File: hdl/cfg_reg_mem.v
/*
 * Small register store for the writable node configuration registers.
 * Assumes one clock, synchronous active-low reset, one access per cycle.
 */
`timescale 1ns/1ps
`include "node_cfg_consts.vh"

module cfg_reg_mem #(
	parameter ADDR_W = 6,
	parameter DATA_W = 32,
	parameter DEPTH  = 40
) (
	input  wire              i_mclk,
	input  wire              i_rst_n,
	input  wire              i_we,
	input  wire              i_re,
	input  wire [ADDR_W-1:0] i_addr,
	input  wire [DATA_W-1:0] i_wdata,
	output reg  [DATA_W-1:0] o_rdata
);

	// ======================================================================
	// Storage words
	// ======================================================================
	reg  [DATA_W-1:0] mem_reg [0:DEPTH-1]; // One word per slot

	genvar g;
	generate
		for (g = 0; g < DEPTH; g = g + 1) begin : g_word
			// Each word clears on reset, loads on a matching write
			always @(posedge i_mclk) begin
				if (!i_rst_n) begin
					mem_reg[g] <= `REG_RESET;
				end else if (i_we && ({{(32-ADDR_W){1'b0}}, i_addr} == g)) begin
					mem_reg[g] <= i_wdata;
				end
			end
		end
	endgenerate

	// ======================================================================
	// Registered read port
	// ======================================================================
	// Read data lands one cycle after the strobe
	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_rdata <= `REG_RESET;
		end else if (i_re) begin
			o_rdata <= (i_addr < DEPTH) ? mem_reg[i_addr] : `REG_RESET;
		end
	end

endmodule // cfg_reg_mem

// File: hdl/node_config_message_port.v
/*
 * Node configuration message port: parses read and write request token
 * streams, accesses the node configuration registers and sends replies.
 * Assumes token streams arrive from interconnect logic on i_mclk, and the
 * boot select pins are asynchronous to i_mclk.
 */
//Function
//- Write request: 192, reply id, number, data, 1
//- Write reply: tokens 3,1 or 4,1
//- Read request: 193, reply id, number, 1
//- Read reply: 3, data word, 1; else 4,1
//- Identification register read-only with id fields
//- Boot pins captured at reset, bits 23:16
//- Switch description reports processors and links
//- Registers reachable only through these messages
`timescale 1ns/1ps
`include "node_cfg_consts.vh"

module node_config_message_port #(
	parameter [7:0] CHIP_ID        = 8'h5A, // Arbitrary value
	parameter [7:0] SW_REVISION    = 8'h01, // Arbitrary value
	parameter [7:0] SW_VERSION     = 8'h02, // Arbitrary value
	parameter [7:0] NUM_PROCESSORS = 8'h01,
	parameter [7:0] NUM_LINKS      = 8'h08
) (
	input  wire        i_mclk,
	input  wire        i_rst_n,
	input  wire        i_boot_select_pin_0,
	input  wire        i_boot_select_pin_1,
	input  wire        i_rx_valid,
	input  wire        i_rx_ctrl,
	input  wire [7:0]  i_rx_data,
	output wire        o_rx_ready,
	output wire        o_tx_valid,
	output wire        o_tx_ctrl,
	output wire [7:0]  o_tx_data,
	output wire [23:0] o_tx_dest,
	input  wire        i_tx_ready,
	input  wire [31:0] i_debug_source,
	output wire [15:0] o_node_id
);

	// ======================================================================
	// States
	// ======================================================================
	localparam [2:0] S_IDLE = 3'h0; // Wait for request header
	localparam [2:0] S_RID  = 3'h1; // Reply channel-end bytes
	localparam [2:0] S_RNUM = 3'h2; // Register number bytes
	localparam [2:0] S_DATA = 3'h3; // Write data bytes
	localparam [2:0] S_END  = 3'h4; // Closing token
	localparam [2:0] S_ACC  = 3'h5; // Register access
	localparam [2:0] S_WAIT = 3'h6; // Read data settles
	localparam [2:0] S_TX   = 3'h7; // Reply tokens out

	// ======================================================================
	// Declarations
	// ======================================================================
	reg  [2:0]  state_reg, state_next;     // Sequencer state
	reg  [1:0]  cnt_reg, cnt_next;         // Bytes to come after the next one
	reg         is_wr_reg, is_wr_next;     // Request is a write
	reg  [23:0] rid_reg, rid_next;         // Reply channel end
	reg  [15:0] rnum_reg, rnum_next;       // Register number
	reg  [31:0] wdata_reg, wdata_next;     // Write data word
	reg         ok_reg, ok_next;           // Access succeeded
	reg  [31:0] shift_reg, shift_next;     // Read data to send
	reg  [2:0]  left_reg, left_next;       // Tokens after current
	reg         tx_valid_reg, tx_valid_next, tx_ctrl_reg, tx_ctrl_next; // Reply flags
	reg  [7:0]  tx_data_reg, tx_data_next;
	reg  [15:0] node_id_reg, node_id_next; // Node id shadow
	reg  [1:0]  pin_s1_reg, pin_s2_reg, pin_s3_reg; // Pin synchroniser stages
	reg  [1:0]  settle_reg;                // Cycles since reset release
	reg         cap_done_reg;              // Boot pins captured
	reg  [1:0]  mode_cap_reg;              // Captured boot pins
	reg         hit, rw;                   // Number known; register writable
	reg  [5:0]  slot;                      // Storage slot
	reg  [31:0] rd_value;                  // Read value selected
	wire        rx_take, tx_take;          // Token accepted; token delivered
	wire        mem_we, mem_re;            // Store write and read strobes
	wire [31:0] mem_rdata;                 // Store read data
	wire [31:0] ident_word, desc_word;     // Identification; switch description
	wire [15:0] rnum_rel = rnum_reg - `RN_SWCFG; // Number within switch group

	// ======================================================================
	// Handshakes and outputs
	// ======================================================================
	// Accept tokens only while parsing; parse states are coded lowest
	assign o_rx_ready = (state_reg <= S_END);
	assign rx_take    = i_rx_valid && o_rx_ready;
	assign tx_take    = tx_valid_reg && i_tx_ready;
	assign o_tx_valid = tx_valid_reg;
	assign o_tx_ctrl  = tx_ctrl_reg;
	assign o_tx_data  = tx_data_reg;
	assign o_tx_dest  = rid_reg;
	assign o_node_id  = node_id_reg;

	// ======================================================================
	// Read-only words
	// ======================================================================
	// Identification: chip, boot pins, revision, version
	assign ident_word = {CHIP_ID, `ID_MODE_PAD, mode_cap_reg, SW_REVISION, SW_VERSION};
	// Description: processors above links
	assign desc_word  = {`DESC_PAD, NUM_PROCESSORS, NUM_LINKS};

	// ======================================================================
	// Register number decode
	// ======================================================================
	// Map the number to a slot and read value; read-only numbers never write
	always @* begin
		hit      = 1'b1;
		rw       = 1'b1;
		slot     = `SLOT_SWCFG;
		rd_value = mem_rdata; // Store answers one cycle after the access
		if (rnum_reg == `RN_IDENT) begin
			rw       = 1'b0;
			rd_value = ident_word;
		end else if (rnum_reg == `RN_SWDESC) begin
			rw       = 1'b0;
			rd_value = desc_word;
		end else if (rnum_reg == `RN_DBGSRC) begin
			rw       = 1'b0;
			rd_value = i_debug_source;
		end else if ((rnum_reg >= `RN_SWCFG) && (rnum_reg <= `RN_REFCLK)) begin
			slot = `SLOT_SWCFG + rnum_rel[5:0];
		end else if ((rnum_reg == `RN_DIRLO) || (rnum_reg == `RN_DIRHI)) begin
			slot = `SLOT_DIRLO + {5'h0, rnum_reg[0]}; // High word in next slot
		end else if (rnum_reg == `RN_DBGPIN) begin
			slot = `SLOT_DBGPIN;
		end else if ((rnum_reg & `RN_GRP8_MASK) == `RN_LINKST) begin
			slot = `SLOT_LINKST + {3'h0, rnum_reg[2:0]};
		end else if ((rnum_reg & `RN_GRP4_MASK) == `RN_PROCESSOR_LINK) begin
			slot = `SLOT_PROCESSOR_LINK + {4'h0, rnum_reg[1:0]};
		end else if ((rnum_reg & `RN_GRP8_MASK) == `RN_LINKCFG) begin
			slot = `SLOT_LINKCFG + {3'h0, rnum_reg[2:0]};
		end else if ((rnum_reg & `RN_GRP8_MASK) == `RN_STATIC) begin
			slot = `SLOT_STATIC + {3'h0, rnum_reg[2:0]};
		end else begin
			hit = 1'b0;
			rw  = 1'b0;
		end
	end

	// Store strobes: write only on a legal write, reading always harmless
	assign mem_we = (state_reg == S_ACC) && is_wr_reg && hit && rw;
	assign mem_re = (state_reg == S_ACC) && !is_wr_reg;

	// ======================================================================
	// Register store
	// ======================================================================
	cfg_reg_mem #(.ADDR_W(6), .DATA_W(32), .DEPTH(40)) u_store (
		.i_mclk  (i_mclk),
		.i_rst_n (i_rst_n),
		.i_we    (mem_we),
		.i_re    (mem_re),
		.i_addr  (slot),
		.i_wdata (wdata_reg),
		.o_rdata (mem_rdata)
	);

	// ======================================================================
	// Message sequencer
	// ======================================================================
	// Parse request, access, then emit the reply
	always @* begin
		state_next    = state_reg;
		cnt_next      = cnt_reg;
		is_wr_next    = is_wr_reg;
		rid_next      = rid_reg;
		rnum_next     = rnum_reg;
		wdata_next    = wdata_reg;
		ok_next       = ok_reg;
		shift_next    = shift_reg;
		left_next     = left_reg;
		tx_valid_next = tx_valid_reg;
		tx_ctrl_next  = tx_ctrl_reg;
		tx_data_next  = tx_data_reg;
		node_id_next  = node_id_reg;
		case (state_reg)
			S_IDLE: begin
				// Header token picks write or read; others dropped
				if (rx_take && i_rx_ctrl &&
				    ((i_rx_data == `TOK_WRITE) || (i_rx_data == `TOK_READ))) begin
					is_wr_next = (i_rx_data == `TOK_WRITE);
					cnt_next   = `CNT_RID;
					state_next = S_RID;
				end
			end
			S_RID: begin
				// Three reply id bytes, most significant first
				if (rx_take && i_rx_ctrl) begin
					state_next = S_IDLE;
				end else if (rx_take) begin
					rid_next = {rid_reg[15:0], i_rx_data};
					cnt_next = cnt_reg - 2'h1;
					if (cnt_reg == 2'h0) begin
						cnt_next   = `CNT_RNUM;
						state_next = S_RNUM;
					end
				end
			end
			S_RNUM: begin
				// Two register number bytes; reads skip the data word
				if (rx_take && i_rx_ctrl) begin
					state_next = S_IDLE;
				end else if (rx_take) begin
					rnum_next = {rnum_reg[7:0], i_rx_data};
					cnt_next  = cnt_reg - 2'h1;
					if (cnt_reg == 2'h0) begin
						cnt_next   = `CNT_DATA;
						state_next = is_wr_reg ? S_DATA : S_END;
					end
				end
			end
			S_DATA: begin
				// Four data bytes of a write
				if (rx_take && i_rx_ctrl) begin
					state_next = S_IDLE;
				end else if (rx_take) begin
					wdata_next = {wdata_reg[23:0], i_rx_data};
					cnt_next   = cnt_reg - 2'h1;
					if (cnt_reg == 2'h0) begin
						state_next = S_END;
					end
				end
			end
			S_END: begin
				// Only the closing token completes a request
				if (rx_take && i_rx_ctrl && (i_rx_data == `TOK_END)) begin
					state_next = S_ACC;
				end else if (rx_take) begin
					state_next = S_IDLE;
				end
			end
			S_ACC: begin
				// Success needs a known number, and a writable one for writes
				ok_next = hit && (rw || !is_wr_reg);
				if (mem_we && (rnum_reg == `RN_NODEID)) begin
					node_id_next = wdata_reg[15:0];
				end
				state_next = S_WAIT;
			end
			S_WAIT: begin
				// First reply token: ack or nack
				shift_next    = rd_value;
				tx_valid_next = 1'b1;
				tx_ctrl_next  = 1'b1;
				tx_data_next  = ok_reg ? `TOK_ACK : `TOK_NACK;
				left_next     = (ok_reg && !is_wr_reg) ? `TX_LEFT_RD : `TX_LEFT_SHORT;
				state_next    = S_TX;
			end
			S_TX: begin
				// Advance on each delivered token
				if (tx_take) begin
					left_next = left_reg - 3'h1;
					if (left_reg == 3'h0) begin
						tx_valid_next = 1'b0;
						tx_ctrl_next  = 1'b0;
						tx_data_next  = 8'h00;
						state_next    = S_IDLE;
					end else if (left_reg == 3'h1) begin
						tx_ctrl_next = 1'b1;
						tx_data_next = `TOK_END;
					end else begin
						tx_ctrl_next = 1'b0;
						tx_data_next = shift_reg[31:24];
						shift_next   = {shift_reg[23:0], 8'h00};
					end
				end
			end
			default: begin
				state_next = S_IDLE;
			end
		endcase
	end

	// Sequencer registers
	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			state_reg    <= S_IDLE;
			cnt_reg      <= 2'h0;
			is_wr_reg    <= 1'b0;
			rid_reg      <= 24'h000000;
			rnum_reg     <= 16'h0000;
			wdata_reg    <= `REG_RESET;
			ok_reg       <= 1'b0;
			shift_reg    <= `REG_RESET;
			left_reg     <= 3'h0;
			tx_valid_reg <= 1'b0;
			tx_ctrl_reg  <= 1'b0;
			tx_data_reg  <= 8'h00;
			node_id_reg  <= 16'h0000;
		end else begin
			state_reg    <= state_next;
			cnt_reg      <= cnt_next;
			is_wr_reg    <= is_wr_next;
			rid_reg      <= rid_next;
			rnum_reg     <= rnum_next;
			wdata_reg    <= wdata_next;
			ok_reg       <= ok_next;
			shift_reg    <= shift_next;
			left_reg     <= left_next;
			tx_valid_reg <= tx_valid_next;
			tx_ctrl_reg  <= tx_ctrl_next;
			tx_data_reg  <= tx_data_next;
			node_id_reg  <= node_id_next;
		end
	end

	// ======================================================================
	// Boot select pin capture
	// ======================================================================
	// Three-stage synchroniser, free running
	always @(posedge i_mclk) begin
		{pin_s3_reg, pin_s2_reg, pin_s1_reg} <= {pin_s2_reg, pin_s1_reg,
		                                         i_boot_select_pin_1, i_boot_select_pin_0};
	end

	// Latch the settled pins once, just after reset release
	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			settle_reg   <= 2'h0;
			cap_done_reg <= 1'b0;
			mode_cap_reg <= 2'h0;
		end else begin
			if (settle_reg != `SYNC_SETTLE) begin
				settle_reg <= settle_reg + 2'h1;
			end else if (!cap_done_reg && (pin_s2_reg == pin_s3_reg)) begin
				mode_cap_reg <= pin_s3_reg;
				cap_done_reg <= 1'b1;
			end
		end
	end

endmodule // node_config_message_port

// File: dv/cfg_requester_model.sv
/*
 * Requester model: a channel end that offers request tokens and takes
 * reply tokens, with stalls chosen by the bench.
 * Assumes the bench calls its tasks and that it shares the port clock.
 */
`timescale 1ns/1ps

module cfg_requester_model #(
	parameter [15:0] NODE_ID = 16'h0001
) (
	input  wire       i_mclk,
	input  wire       i_rx_ready,
	input  wire       i_tx_valid,
	input  wire       i_tx_ctrl,
	input  wire [7:0] i_tx_data,
	output reg        o_rx_valid,
	output reg        o_rx_ctrl,
	output reg  [7:0] o_rx_data,
	output reg        o_tx_ready
);
	// Destination word of this channel end
	wire [31:0] dest_word = {NODE_ID, 16'hC30C};

	initial begin
		o_rx_valid = 1'b0;
		o_rx_ctrl  = 1'b0;
		o_rx_data  = 8'hA5;
		o_tx_ready = 1'b0;
	end

	// Offer one token, hold until taken; next call runs back to back
	task send(input reg c, input reg [7:0] d);
		@(negedge i_mclk);
		o_rx_valid = 1'b1;
		o_rx_ctrl  = c;
		o_rx_data  = d;
		@(posedge i_mclk);
		while (!i_rx_ready) @(posedge i_mclk);
	endtask

	// Released link shows inverted last values, not stale ones
	task release_bus;
		@(negedge i_mclk);
		o_rx_valid = 1'b0;
		o_rx_ctrl  = ~o_rx_ctrl;
		o_rx_data  = ~o_rx_data;
	endtask

	// Take one reply token after w stall cycles
	task recv(input integer w, output reg c, output reg [7:0] d);
		repeat (w) @(negedge i_mclk);
		@(negedge i_mclk);
		o_tx_ready = 1'b1;
		@(posedge i_mclk);
		while (!i_tx_valid) @(posedge i_mclk);
		c = i_tx_ctrl;
		d = i_tx_data;
		@(negedge i_mclk);
		o_tx_ready = 1'b0;
	endtask
endmodule // cfg_requester_model

// File: dv/node_config_message_port_assertions.sv
/*
 * Checker of the message port: reply framing, timing and storage.
 * Assumes binding to the port module and its single clock domain.
 */
`timescale 1ns/1ps

module node_config_message_port_assertions (
	input wire        i_mclk,
	input wire        i_rst_n,
	input wire        i_rx_valid,
	input wire        i_rx_ctrl,
	input wire [7:0]  i_rx_data,
	input wire        o_rx_ready,
	input wire        o_tx_valid,
	input wire        o_tx_ctrl,
	input wire [7:0]  o_tx_data,
	input wire [23:0] o_tx_dest,
	input wire        i_tx_ready,
	input wire [15:0] o_node_id
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);

	// =====================================================================
	// Reply stream and node id
	// =====================================================================
	property p_tx_hold;
		o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable({o_tx_ctrl, o_tx_data});
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("reply token dropped");
	property p_first_ctrl;
		$rose(o_tx_valid) |-> o_tx_ctrl && (o_tx_data == 8'h03 || o_tx_data == 8'h04);
	endproperty
	a_first_ctrl: assert property (p_first_ctrl) else $error("bad first reply");
	property p_reply_latency;
		o_rx_ready && i_rx_valid && i_rx_ctrl && i_rx_data == 8'h01 ##1 !o_rx_ready
			|-> ##2 $rose(o_tx_valid);
	endproperty
	a_reply_latency: assert property (p_reply_latency) else $error("reply late");
	property p_busy_reply;
		o_tx_valid |-> !o_rx_ready;
	endproperty
	a_busy_reply: assert property (p_busy_reply) else $error("ready in reply");
	property p_nack_end;
		o_tx_valid && o_tx_ctrl && o_tx_data == 8'h04 && i_tx_ready
			|=> o_tx_valid && o_tx_ctrl && o_tx_data == 8'h01;
	endproperty
	a_nack_end: assert property (p_nack_end) else $error("failure not closed");
	property p_ack_next;
		o_tx_valid && o_tx_ctrl && o_tx_data == 8'h03 && i_tx_ready
			|=> o_tx_valid && (!o_tx_ctrl || o_tx_data == 8'h01);
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("bad token after ack");
	property p_end_closes;
		o_tx_valid && o_tx_ctrl && o_tx_data == 8'h01 && i_tx_ready |=> !o_tx_valid && o_rx_ready;
	endproperty
	a_end_closes: assert property (p_end_closes) else $error("reply not closed");
	property p_dest_stable;
		o_tx_valid ##1 o_tx_valid |-> $stable(o_tx_dest);
	endproperty
	a_dest_stable: assert property (p_dest_stable) else $error("dest moved");
	property p_store_by_msg;
		$changed(o_node_id) |-> !$past(o_rx_ready) && !o_rx_ready;
	endproperty
	a_store_by_msg: assert property (p_store_by_msg) else $error("node id moved");
endmodule // node_config_message_port_assertions

bind node_config_message_port node_config_message_port_assertions
	node_config_message_port_assertions_inst (
	.i_mclk     (i_mclk),
	.i_rst_n    (i_rst_n),
	.i_rx_valid (i_rx_valid),
	.i_rx_ctrl  (i_rx_ctrl),
	.i_rx_data  (i_rx_data),
	.o_rx_ready (o_rx_ready),
	.o_tx_valid (o_tx_valid),
	.o_tx_ctrl  (o_tx_ctrl),
	.o_tx_data  (o_tx_data),
	.o_tx_dest  (o_tx_dest),
	.i_tx_ready (i_tx_ready),
	.o_node_id  (o_node_id)
);

// File: dv/node_config_message_port_tb_top.sv
/*
 * Bench of the message port: reference store, full register sweeps,
 * aborted requests and a second reset with new boot pins.
 * Assumes the requester model and the bound checker.
 */
`timescale 1ns/1ps

`define CHK(nm, e, g) \
	begin \
		checked = checked + 1; \
		if ((g) !== (e)) begin \
			n_errors = n_errors + 1; \
			$display("ERROR %s expected %0h seen %0h", nm, e, g); \
		end \
	end

module node_config_message_port_tb_top;
	reg         mclk = 1'b0;          // Port clock
	reg         rst_n = 1'b0;         // Sync reset
	reg  [1:0]  boot = 2'h2;          // Boot select pins
	reg  [31:0] dbg_src = 32'h0;      // Debug source input
	wire        rx_valid, rx_ctrl, rx_ready, tx_valid, tx_ctrl, tx_ready;
	wire [7:0]  rx_data, tx_data;
	wire [23:0] tx_dest;
	wire [15:0] node_id;
	integer     n_errors = 0;
	integer     checked = 0;
	integer     seed = 25;
	integer     cycles = 0;
	integer     i;
	reg  [31:0] mem [0:255];          // Reference store
	wire [31:0] ident = {8'h3C, 6'h00, boot, 8'h01, 8'h02};

	always #5 mclk = ~mclk;

	// Hang guard
	always @(posedge mclk) begin
		cycles = cycles + 1;
		if (cycles == 60000) begin
			n_errors = n_errors + 1;
			final_report;
		end
	end

	node_config_message_port #(.CHIP_ID(8'h3C), .NUM_LINKS(8'h04))
		node_config_message_port_inst (
		.i_mclk(mclk), .i_rst_n(rst_n), .i_boot_select_pin_0(boot[0]),
		.i_boot_select_pin_1(boot[1]), .i_rx_valid(rx_valid), .i_rx_ctrl(rx_ctrl),
		.i_rx_data(rx_data), .o_rx_ready(rx_ready), .o_tx_valid(tx_valid),
		.o_tx_ctrl(tx_ctrl), .o_tx_data(tx_data), .o_tx_dest(tx_dest),
		.i_tx_ready(tx_ready), .i_debug_source(dbg_src), .o_node_id(node_id));

	cfg_requester_model cfg_requester_model_inst (
		.i_mclk(mclk), .i_rx_ready(rx_ready), .i_tx_valid(tx_valid),
		.i_tx_ctrl(tx_ctrl), .i_tx_data(tx_data), .o_rx_valid(rx_valid),
		.o_rx_ctrl(rx_ctrl), .o_rx_data(rx_data), .o_tx_ready(tx_ready));

	// Read-only numbers
	function automatic bit ro(input [15:0] n);
		ro = n == 16'h0000 || n == 16'h0001 || n == 16'h001F;
	endfunction

	// Implemented numbers
	function automatic bit hit(input [15:0] n);
		hit = ro(n) || (n >= 16'h0004 && n <= 16'h0008) || n == 16'h000C
			|| n == 16'h000D || n == 16'h0010 || n[15:3] == 13'h0004
			|| n[15:2] == 14'h0010 || n[15:3] == 13'h0010 || n[15:3] == 13'h0014;
	endfunction

	// One request and its whole reply, checked token by token
	task req(input reg wr, input [15:0] n, input [31:0] d);
		reg [23:0] id;
		reg [31:0] v;
		reg        ok;
		reg        c;
		reg [7:0]  b;
		reg [8:0]  q [$];
		integer    k;
		id = 24'($random(seed));
		ok = hit(n) && !(wr && ro(n));
		v = n == 16'h0 ? ident : n == 16'h1 ? {16'h0, 8'h01, 8'h04} :
			n == 16'h1F ? dbg_src : mem[n[7:0]];
		cfg_requester_model_inst.send(1'b1, wr ? 8'hC0 : 8'hC1);
		for (k = 16; k >= 0; k = k - 8) cfg_requester_model_inst.send(1'b0, id[k +: 8]);
		for (k = 8; k >= 0; k = k - 8) cfg_requester_model_inst.send(1'b0, n[k +: 8]);
		for (k = 24; wr && k >= 0; k = k - 8) cfg_requester_model_inst.send(1'b0, d[k +: 8]);
		cfg_requester_model_inst.send(1'b1, 8'h01);
		cfg_requester_model_inst.release_bus;
		if (ok && wr) mem[n[7:0]] = d;
		q = {ok ? 9'h103 : 9'h104};
		for (k = 24; ok && !wr && k >= 0; k = k - 8) q.push_back({1'b0, v[k +: 8]});
		q.push_back(9'h101);
		for (k = 0; k < q.size(); k = k + 1) begin
			cfg_requester_model_inst.recv($random(seed) & 3, c, b);
			`CHK("reply token", q[k], {c, b})
		end
		`CHK("reply dest", id, tx_dest)
	endtask

	// Reset with new pins; store returns to zero
	task do_reset;
		rst_n = 1'b0;
		boot = 2'($random(seed));
		dbg_src = $random(seed);
		for (i = 0; i < 256; i = i + 1) mem[i] = 32'h0;
		repeat (5) @(negedge mclk);
		rst_n = 1'b1;
		repeat (10) @(negedge mclk);
	endtask

	task final_report;
		$display("Comparisons %0d, mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Main sequence
	initial begin
		do_reset;
		for (i = 0; i < 176; i = i + 1) req(1'b0, 16'(i), 32'h0);
		for (i = 0; i < 176; i = i + 1) req(1'b1, 16'(i), $random(seed));
		`CHK("node id", mem[5][15:0], node_id)
		for (i = 0; i < 176; i = i + 1) req(1'b0, 16'(i), 32'h0);
		req(1'b0, 16'hFFFF, 32'h0);
		req(1'b1, 16'h0100, 32'h1234_5678);
		// Aborted write, dropped idle token, then read with bad closer
		cfg_requester_model_inst.send(1'b1, 8'hC0);
		cfg_requester_model_inst.send(1'b0, 8'h11);
		cfg_requester_model_inst.send(1'b1, 8'h01);
		cfg_requester_model_inst.send(1'b0, 8'h55);
		cfg_requester_model_inst.send(1'b1, 8'hC1);
		for (i = 0; i < 4; i = i + 1) cfg_requester_model_inst.send(1'b0, 8'h00);
		cfg_requester_model_inst.send(1'b0, 8'h05);
		cfg_requester_model_inst.send(1'b1, 8'hC0);
		cfg_requester_model_inst.release_bus;
		repeat (8) @(negedge mclk);
		`CHK("no reply", 1'b0, tx_valid)
		req(1'b0, 16'h0005, 32'h0);
		do_reset;
		`CHK("node id reset", 16'h0, node_id)
		req(1'b0, 16'h0000, 32'h0);
		req(1'b0, 16'h00A7, 32'h0);
		req(1'b0, 16'h001F, 32'h0);
		final_report;
	end
endmodule // node_config_message_port_tb_top
